/* File: cfs_pkg.sv */
`default_nettype none
// ==========================================================
// Overview of operation
// - detect three failure kinds: SCADA link, battery link, internal link.
// - separate SCADA and battery tolerance times; internal uses the shorter.
// - standard mode: enter fallback only after the applicable tolerance fully expires.
// - detection status reads Ok, Fallback or Error.
// - per-path enables; a healthy path keeps supplying its setpoints.
// - Error after the fallback duration; zero duration means Error at once.
// - standard mode: valid setpoints return clear the error.
// - behaviour Error: Error state, AC disconnect and DC switchgear open.
// - behaviour Standby: Standby state, AC and DC switchgear stay closed.
// - behaviour Predefined: control mode power, DC voltage or last mode.
// - stored substitutes for P, Q, power factor, DC and nominal voltage.
// - behaviour Last setpoint: reuse last value, Standby if none ever came.
// - an enable switches to the enhanced handling.
// - enhanced: after fault time, warning 9348, 30 s status and recheck.
// - still lost after recheck: fallback, then Error with error 6136.
// - enhanced Error leaves only when link is back and clear is written.
// - recovered within recheck: watch 60 minutes, report one-hour status.
// - failure inside the watch: fallback, Error, 6136, manual clear.
// - quiet watch: fault resolved, status inactive, next fault rechecks.
// - frequency power behaviour comes from its own fallback mode setting.
package cfs_pkg;
	// ==========================================================
	// widths and timing
	localparam int TIME_W = 16;
	localparam int VAL_W = 16;
	localparam int NUM_LINKS = 3;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SECOND_NS = 1000000000;
	localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int RECHECK_SEC = 30;
	localparam int WATCH_MIN = 60;
	localparam int WATCH_SEC = WATCH_MIN * 60;
	localparam int SPT_SPACING_MS = 50;
	// ==========================================================
	// event codes (9348 and 6136 decimal)
	localparam logic [15:0] WARN_CODE = 16'h2484;
	localparam logic [15:0] ERR_CODE = 16'h17F8;
	localparam logic [15:0] CODE_NONE = 16'h0000;
	localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
	// ==========================================================
	// types
	typedef enum logic [2:0]
	{
		ST_OK = 3'h0,
		ST_RECHECK = 3'h1,
		ST_WATCH = 3'h3,
		ST_FALLBACK = 3'h2,
		ST_ERROR = 3'h6
	} cfs_state_t;
	typedef enum logic [1:0] {DS_OK = 2'h0, DS_FALLBACK = 2'h1, DS_ERROR = 2'h2} cfs_detect_t;
	typedef enum logic [1:0] {ES_INACTIVE = 2'h0, ES_T30 = 2'h1, ES_T1H = 2'h2, ES_FLB_ERR = 2'h3} cfs_enh_t;
	typedef enum logic [1:0] {FB_ERROR = 2'h0, FB_STANDBY = 2'h1, FB_PREDEF = 2'h2, FB_LAST = 2'h3} cfs_behav_t;
	typedef enum logic [1:0] {CM_POWER = 2'h0, CM_DCVOLT = 2'h1, CM_LAST = 2'h2} cfs_ctl_t;
	typedef enum logic [1:0] {OP_FEED = 2'h0, OP_STANDBY = 2'h1, OP_ERROR = 2'h2} cfs_op_t;
endpackage : cfs_pkg
`default_nettype wire

/* File: cfs_sec_timer.sv */
`default_nettype none
module cfs_sec_timer #(parameter int W = cfs_pkg::TIME_W)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic clear,
	input wire logic run,
	output logic [W-1:0] secsReg
);
	import cfs_pkg::*;
	// ==========================================================
	// seconds counter; saturates so a long outage never wraps under a limit
	always_ff @(posedge ref_clk)
	begin
		if (rst || clear)
			secsReg <= '0;
		else if (run && tick && secsReg != '1)
			secsReg <= secsReg + 1'b1;
	end
endmodule : cfs_sec_timer
`default_nettype wire

/* File: cfs_supervisor.sv */
`default_nettype none
module cfs_supervisor #(parameter int TICK_CYCLES = cfs_pkg::TICK_CYCLES)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scadaLinkFail,
	input wire logic batteryLinkFail,
	input wire logic internalLinkFail,
	input wire logic scadaSetpointValid,
	input wire logic batterySetpointValid,
	input wire logic [cfs_pkg::VAL_W-1:0] scadaActivePower,
	input wire logic [cfs_pkg::VAL_W-1:0] scadaReactivePower,
	input wire logic [cfs_pkg::VAL_W-1:0] scadaPowerFactor,
	input wire logic [cfs_pkg::VAL_W-1:0] scadaNominalVoltage,
	input wire logic [cfs_pkg::VAL_W-1:0] batteryDcVoltage,
	input wire cfs_pkg::cfs_ctl_t liveControlMode,
	input wire logic [1:0] freqPowerNormalMode,
	input wire logic [1:0] freqPowerFallbackMode,
	input wire logic scadaPathEnable,
	input wire logic batteryPathEnable,
	input wire logic [cfs_pkg::TIME_W-1:0] scadaToleranceTime,
	input wire logic [cfs_pkg::TIME_W-1:0] batteryToleranceTime,
	input wire logic [cfs_pkg::TIME_W-1:0] fallbackDurationLimit,
	input wire cfs_pkg::cfs_behav_t fallbackBehaviourSelect,
	input wire cfs_pkg::cfs_ctl_t fallbackControlMode,
	input wire logic [cfs_pkg::VAL_W-1:0] substituteActivePower,
	input wire logic [cfs_pkg::VAL_W-1:0] substituteReactivePower,
	input wire logic [cfs_pkg::VAL_W-1:0] substitutePowerFactor,
	input wire logic [cfs_pkg::VAL_W-1:0] substituteDcVoltage,
	input wire logic [cfs_pkg::VAL_W-1:0] substituteNominalVoltage,
	input wire logic enhancedHandlingEnable,
	input wire logic [cfs_pkg::TIME_W-1:0] enhancedFaultTime,
	input wire logic [cfs_pkg::TIME_W-1:0] enhancedFallbackTime,
	input wire logic enhancedErrorClear,
	output cfs_pkg::cfs_detect_t detectionStatus,
	output cfs_pkg::cfs_enh_t enhancedStatus,
	output cfs_pkg::cfs_op_t operatingState,
	output logic feedingState,
	output logic acDisconnectOpen,
	output logic dcSwitchgearOpen,
	output logic scadaPathEnableRd,
	output logic batteryPathEnableRd,
	output logic [cfs_pkg::NUM_LINKS-1:0] failureCause,
	output logic [15:0] warningCode,
	output logic [15:0] errorCode,
	output logic [cfs_pkg::VAL_W-1:0] appliedActivePower,
	output logic [cfs_pkg::VAL_W-1:0] appliedReactivePower,
	output logic [cfs_pkg::VAL_W-1:0] appliedPowerFactor,
	output logic [cfs_pkg::VAL_W-1:0] appliedDcVoltage,
	output logic [cfs_pkg::VAL_W-1:0] appliedNominalVoltage,
	output cfs_pkg::cfs_ctl_t appliedControlMode,
	output logic [1:0] freqPowerMode
);
	import cfs_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic timeUp(input logic [TIME_W-1:0] secs, input logic [TIME_W-1:0] lim);
		timeUp = secs > lim; // strictly past, so never early
	endfunction : timeUp

	function automatic cfs_detect_t statusOf(input cfs_state_t st);
		if (st == ST_FALLBACK)
			statusOf = DS_FALLBACK;
		else if (st == ST_ERROR)
			statusOf = DS_ERROR;
		else
			statusOf = DS_OK;
	endfunction : statusOf

	// ==========================================================
	// pin synchronisers
	logic [NUM_LINKS-1:0] failPins;
	logic [NUM_LINKS-1:0] failMeta;
	logic [NUM_LINKS-1:0] failSync;
	assign failPins = {internalLinkFail, batteryLinkFail, scadaLinkFail};

	// fail levels are asynchronous pins; the first stage feeds only the second
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			failMeta <= '0;
			failSync <= '0;
		end
		else
		begin
			failMeta <= failPins;
			failSync <= failMeta;
		end
	end

	// ==========================================================
	// one-second tick
	logic [31:0] tickCountReg;
	logic secTickReg;

	always_ff @(posedge ref_clk)
	begin
		if (rst || tickCountReg == 32'(TICK_CYCLES - 1))
			tickCountReg <= '0;
		else
			tickCountReg <= tickCountReg + 32'd1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			secTickReg <= 1'b0;
		else
			secTickReg <= tickCountReg == 32'(TICK_CYCLES - 1);
	end

	// ==========================================================
	// per-link tolerance timers
	logic [NUM_LINKS-1:0] pathEnable;
	logic [NUM_LINKS-1:0] validStrobe;
	logic [NUM_LINKS-1:0] linkDown;
	logic [NUM_LINKS-1:0] tolExpired;
	logic [NUM_LINKS-1:0] enhExpired;
	logic [TIME_W-1:0] linkSecs [NUM_LINKS];
	logic [TIME_W-1:0] tolLimit [NUM_LINKS];
	logic anyExpired;
	logic enhFaultUp;
	logic commLost;
	logic anyValid;

	// internal link has no enable and no setpoint of its own
	assign pathEnable = {1'b1, batteryPathEnable, scadaPathEnable};
	assign validStrobe = {1'b0, batterySetpointValid, scadaSetpointValid};
	assign linkDown = failSync & pathEnable;
	assign tolLimit[0] = scadaToleranceTime;
	assign tolLimit[1] = batteryToleranceTime;
	assign tolLimit[2] = (scadaToleranceTime < batteryToleranceTime) ?
		scadaToleranceTime : batteryToleranceTime;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINKS; gi++)
		begin : g_link
			cfs_sec_timer #(.W(TIME_W)) u_timer
			(
				.ref_clk(ref_clk),
				.rst(rst),
				.tick(secTickReg),
				.clear(!linkDown[gi] || validStrobe[gi]),
				.run(linkDown[gi]),
				.secsReg(linkSecs[gi])
			);
			assign tolExpired[gi] = linkDown[gi] && timeUp(linkSecs[gi], tolLimit[gi]);
			assign enhExpired[gi] = linkDown[gi] && timeUp(linkSecs[gi], enhancedFaultTime);
		end
	endgenerate

	assign anyExpired = |tolExpired;
	assign enhFaultUp = |enhExpired;
	assign commLost = |linkDown;
	assign anyValid = scadaSetpointValid || batterySetpointValid;

	// ==========================================================
	// supervision state machine
	cfs_state_t stateReg;
	cfs_state_t stateNext;
	logic enhPathReg;
	logic enhPathNext;
	logic [TIME_W-1:0] stateSecs;
	logic [TIME_W-1:0] fbLimit;

	// enhanced sequence uses its own fallback time
	assign fbLimit = enhPathReg ? enhancedFallbackTime : fallbackDurationLimit;

	cfs_sec_timer #(.W(TIME_W)) u_state_timer
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(secTickReg),
		.clear(stateNext != stateReg),
		.run(1'b1),
		.secsReg(stateSecs)
	);

	// next state
	always_comb
	begin
		stateNext = stateReg;
		unique case (stateReg)
			ST_OK:
				if (enhancedHandlingEnable && enhFaultUp)
					stateNext = ST_RECHECK;
				else if (!enhancedHandlingEnable && anyExpired)
					stateNext = ST_FALLBACK;
			ST_RECHECK:
				if (!commLost)
					stateNext = ST_WATCH;
				else if (stateSecs >= TIME_W'(RECHECK_SEC))
					stateNext = ST_FALLBACK;
			ST_WATCH:
				if (commLost)
					stateNext = ST_FALLBACK;
				else if (stateSecs >= TIME_W'(WATCH_SEC))
					stateNext = ST_OK;
			ST_FALLBACK:
				if (!enhPathReg && !commLost && anyValid)
					stateNext = ST_OK;
				else if (stateSecs >= fbLimit)
					stateNext = ST_ERROR;
			ST_ERROR:
				if (enhPathReg ? (!commLost && enhancedErrorClear) : (!commLost && anyValid))
					stateNext = ST_OK;
			default:
				stateNext = ST_OK; // three codes are unused
		endcase
	end

	// the enhanced path is remembered until the sequence ends in Ok
	always_comb
	begin
		enhPathNext = enhPathReg;
		if (stateNext == ST_RECHECK)
			enhPathNext = 1'b1;
		else if (stateNext == ST_OK)
			enhPathNext = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			stateReg <= ST_OK;
			enhPathReg <= 1'b0;
		end
		else
		begin
			stateReg <= stateNext;
			enhPathReg <= enhPathNext;
		end
	end

	// ==========================================================
	// last valid setpoints per path
	logic haveSetpointReg;
	logic [VAL_W-1:0] lastActiveReg;
	logic [VAL_W-1:0] lastReactiveReg;
	logic [VAL_W-1:0] lastPfReg;
	logic [VAL_W-1:0] lastNominalReg;
	logic [VAL_W-1:0] lastDcReg;
	cfs_ctl_t lastCtlModeReg;

	// each path latches only its own values, so one dead path leaves the other live
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			haveSetpointReg <= 1'b0;
			lastActiveReg <= VAL_RST;
			lastReactiveReg <= VAL_RST;
			lastPfReg <= VAL_RST;
			lastNominalReg <= VAL_RST;
			lastDcReg <= VAL_RST;
		end
		else
		begin
			if (anyValid)
				haveSetpointReg <= 1'b1;
			if (scadaSetpointValid)
			begin
				lastActiveReg <= scadaActivePower;
				lastReactiveReg <= scadaReactivePower;
				lastPfReg <= scadaPowerFactor;
				lastNominalReg <= scadaNominalVoltage;
			end
			if (batterySetpointValid)
				lastDcReg <= batteryDcVoltage;
		end
	end

	// control mode in use outside Fallback and Error
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			lastCtlModeReg <= CM_POWER;
		else if (stateReg != ST_FALLBACK && stateReg != ST_ERROR)
			lastCtlModeReg <= liveControlMode;
	end

	// ==========================================================
	// fallback behaviour decode
	logic fbNext;
	logic errNext;
	logic useSub;
	logic scadaSideDown;
	logic batSideDown;
	cfs_op_t opNext;
	cfs_ctl_t ctlNext;

	assign fbNext = stateNext == ST_FALLBACK;
	assign errNext = stateNext == ST_ERROR;
	assign useSub = fbNext && fallbackBehaviourSelect == FB_PREDEF;
	// an internal failure spoils both paths
	assign scadaSideDown = linkDown[0] || linkDown[2];
	assign batSideDown = linkDown[1] || linkDown[2];

	always_comb
	begin
		opNext = OP_FEED;
		if (errNext)
			opNext = OP_ERROR;
		else if (fbNext)
		begin
			unique case (fallbackBehaviourSelect)
				FB_ERROR: opNext = OP_ERROR;
				FB_STANDBY: opNext = OP_STANDBY;
				FB_PREDEF: opNext = OP_FEED;
				FB_LAST: opNext = haveSetpointReg ? OP_FEED : OP_STANDBY;
			endcase
		end
	end

	// predefined mode picks a stored target or keeps the last mode
	always_comb
	begin
		ctlNext = liveControlMode;
		if (useSub)
			ctlNext = (fallbackControlMode == CM_LAST) ? lastCtlModeReg : fallbackControlMode;
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			operatingState <= OP_FEED;
			feedingState <= 1'b1;
			acDisconnectOpen <= 1'b0;
			dcSwitchgearOpen <= 1'b0;
		end
		else
		begin
			operatingState <= opNext;
			feedingState <= opNext == OP_FEED;
			acDisconnectOpen <= opNext == OP_ERROR;
			dcSwitchgearOpen <= opNext == OP_ERROR;
		end
	end

	// status words follow the next state so they line up with stateReg
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			detectionStatus <= DS_OK;
			enhancedStatus <= ES_INACTIVE;
			failureCause <= '0;
			scadaPathEnableRd <= 1'b0;
			batteryPathEnableRd <= 1'b0;
		end
		else
		begin
			detectionStatus <= statusOf(stateNext);
			failureCause <= linkDown;
			scadaPathEnableRd <= scadaPathEnable;
			batteryPathEnableRd <= batteryPathEnable;
			unique case (stateNext)
				ST_RECHECK: enhancedStatus <= ES_T30;
				ST_WATCH: enhancedStatus <= ES_T1H;
				ST_ERROR: enhancedStatus <= enhPathNext ? ES_FLB_ERR : ES_INACTIVE;
				ST_OK: enhancedStatus <= ES_INACTIVE;
				default: enhancedStatus <= enhancedStatus;
			endcase
		end
	end

	// warning stands from the recheck until Ok; error only in enhanced Error
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			warningCode <= CODE_NONE;
			errorCode <= CODE_NONE;
		end
		else
		begin
			if (stateNext == ST_RECHECK)
				warningCode <= WARN_CODE;
			else if (stateNext == ST_OK)
				warningCode <= CODE_NONE;
			errorCode <= (errNext && enhPathNext) ? ERR_CODE : CODE_NONE;
		end
	end

	// substitutes replace only the values of a failed path
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			appliedActivePower <= VAL_RST;
			appliedReactivePower <= VAL_RST;
			appliedPowerFactor <= VAL_RST;
			appliedNominalVoltage <= VAL_RST;
			appliedDcVoltage <= VAL_RST;
			appliedControlMode <= CM_POWER;
			freqPowerMode <= 2'h0;
		end
		else
		begin
			appliedActivePower <= (useSub && scadaSideDown) ? substituteActivePower : lastActiveReg;
			appliedReactivePower <= (useSub && scadaSideDown) ? substituteReactivePower : lastReactiveReg;
			appliedPowerFactor <= (useSub && scadaSideDown) ? substitutePowerFactor : lastPfReg;
			appliedNominalVoltage <= (useSub && scadaSideDown) ? substituteNominalVoltage : lastNominalReg;
			appliedDcVoltage <= (useSub && batSideDown) ? substituteDcVoltage : lastDcReg;
			appliedControlMode <= ctlNext;
			freqPowerMode <= (fbNext || errNext) ? freqPowerFallbackMode : freqPowerNormalMode;
		end
	end

	// ==========================================================
	// assertions
	// checked against the raw limits; the internal link need only pass the shorter one
	no_early_fb_a: assert property (@(posedge ref_clk) disable iff (rst)
		(stateReg == ST_OK && stateNext == ST_FALLBACK) |-> !enhancedHandlingEnable
		&& ((failSync[0] && scadaPathEnable && linkSecs[0] > scadaToleranceTime)
		|| (failSync[1] && batteryPathEnable && linkSecs[1] > batteryToleranceTime)
		|| (failSync[2] && (linkSecs[2] > scadaToleranceTime || linkSecs[2] > batteryToleranceTime))))
		else $error("fallback entered before tolerance expired");

	zero_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
		(stateReg == ST_FALLBACK && !enhPathReg && fallbackDurationLimit == '0 && !anyValid)
		|=> stateReg == ST_ERROR && operatingState == OP_ERROR)
		else $error("zero fallback duration did not give Error");

	status_map_a: assert property (@(posedge ref_clk) disable iff (rst)
		detectionStatus == statusOf(stateReg))
		else $error("detection status does not match state");

	err_open_a: assert property (@(posedge ref_clk) disable iff (rst)
		(stateReg == ST_ERROR) |-> acDisconnectOpen && dcSwitchgearOpen && !feedingState)
		else $error("Error state with switchgear closed");

	standby_closed_a: assert property (@(posedge ref_clk) disable iff (rst)
		(operatingState == OP_STANDBY) |-> !acDisconnectOpen && !dcSwitchgearOpen)
		else $error("Standby opened switchgear");

	no_last_spt_a: assert property (@(posedge ref_clk) disable iff (rst)
		(stateNext == ST_FALLBACK && fallbackBehaviourSelect == FB_LAST && !haveSetpointReg)
		|=> operatingState == OP_STANDBY)
		else $error("no last setpoint but not Standby");

	recheck_warn_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(stateReg == ST_RECHECK) |-> warningCode == WARN_CODE && enhancedStatus == ES_T30)
		else $error("recheck entered without warning");

	manual_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		(stateReg == ST_ERROR && enhPathReg && !enhancedErrorClear) |=> stateReg == ST_ERROR)
		else $error("enhanced Error left without clear");

	err_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		(stateReg == ST_ERROR && enhPathReg) |-> errorCode == ERR_CODE ##0 enhancedStatus == ES_FLB_ERR)
		else $error("enhanced Error without error code");

	watch_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		(stateReg == ST_WATCH && !commLost && stateSecs >= TIME_W'(WATCH_SEC))
		|=> stateReg == ST_OK ##1 enhancedStatus == ES_INACTIVE)
		else $error("watch window did not close to inactive");
endmodule : cfs_supervisor
`default_nettype wire

/* File: cfs_setpoint_source.sv */
`default_nettype none
// ============
// controller and battery sending setpoint frames
module cfs_setpoint_source
	import cfs_pkg::*;
#(parameter int GAP = 2)
(
	input wire logic ref_clk,
	output logic scadaSetpointValid,
	output logic [cfs_pkg::VAL_W-1:0] scadaActivePower,
	output logic [cfs_pkg::VAL_W-1:0] scadaReactivePower,
	output logic [cfs_pkg::VAL_W-1:0] scadaPowerFactor,
	output logic [cfs_pkg::VAL_W-1:0] scadaNominalVoltage,
	output logic batterySetpointValid,
	output logic [cfs_pkg::VAL_W-1:0] batteryDcVoltage
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle lines start on an odd pattern, never a plausible value
	initial
	begin
		scadaSetpointValid = 1'b0;
		batterySetpointValid = 1'b0;
		{scadaActivePower, scadaReactivePower} = {16'h5A5A, 16'hA5A5};
		{scadaPowerFactor, scadaNominalVoltage, batteryDcVoltage} = {16'h5A5A, 16'hA5A5, 16'h5A5A};
	end
	// four words go out together under one strobe
	task sendScada(input logic [VAL_W-1:0] v);
		repeat (GAP) @(negedge ref_clk);
		{scadaActivePower, scadaReactivePower} = {v, v + 16'h0001};
		{scadaPowerFactor, scadaNominalVoltage} = {v + 16'h0002, v + 16'h0003};
		scadaSetpointValid = 1'b1;
		@(negedge ref_clk);
		scadaSetpointValid = 1'b0;
		// released words flip so a stale sample shows up as wrong
		{scadaActivePower, scadaReactivePower} = ~{scadaActivePower, scadaReactivePower};
		{scadaPowerFactor, scadaNominalVoltage} = ~{scadaPowerFactor, scadaNominalVoltage};
	endtask : sendScada
	// battery frame carries the dc voltage alone
	task sendBattery(input logic [VAL_W-1:0] v);
		repeat (GAP) @(negedge ref_clk);
		batteryDcVoltage = v;
		batterySetpointValid = 1'b1;
		@(negedge ref_clk);
		batterySetpointValid = 1'b0;
		batteryDcVoltage = ~batteryDcVoltage;
	endtask : sendBattery
endmodule : cfs_setpoint_source
`default_nettype wire

/* File: test_comm_fallback_supervisor.sv */
`default_nettype none
module test_comm_fallback_supervisor;
	timeunit 1ns;
	timeprecision 1ns;
	import cfs_pkg::*;
	// one second is ten cycles so the hour watch fits the run
	localparam int TK = 10;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic scadaLinkFail = 1'b0, batteryLinkFail = 1'b0, internalLinkFail = 1'b0;
	logic scadaSetpointValid, batterySetpointValid;
	logic [VAL_W-1:0] scadaActivePower, scadaReactivePower, scadaPowerFactor, scadaNominalVoltage;
	logic [VAL_W-1:0] batteryDcVoltage;
	cfs_ctl_t liveControlMode = CM_DCVOLT, fallbackControlMode = CM_POWER, appliedControlMode;
	logic [1:0] freqPowerNormalMode = 2'h1, freqPowerFallbackMode = 2'h2, freqPowerMode;
	logic scadaPathEnable = 1'b1, batteryPathEnable = 1'b1;
	logic [TIME_W-1:0] scadaToleranceTime = 16'h0002, batteryToleranceTime = 16'h0001;
	logic [TIME_W-1:0] fallbackDurationLimit = 16'h0003;
	cfs_behav_t fallbackBehaviourSelect = FB_LAST;
	logic [VAL_W-1:0] substituteActivePower = 16'hA001, substituteReactivePower = 16'hA002;
	logic [VAL_W-1:0] substitutePowerFactor = 16'hA003, substituteDcVoltage = 16'hA004;
	logic [VAL_W-1:0] substituteNominalVoltage = 16'hA005;
	logic enhancedHandlingEnable = 1'b0, enhancedErrorClear = 1'b0;
	logic [TIME_W-1:0] enhancedFaultTime = 16'h0001, enhancedFallbackTime = 16'h0002;
	cfs_detect_t detectionStatus;
	cfs_enh_t enhancedStatus;
	cfs_op_t operatingState;
	logic feedingState, acDisconnectOpen, dcSwitchgearOpen, scadaPathEnableRd, batteryPathEnableRd;
	logic [NUM_LINKS-1:0] failureCause;
	logic [15:0] warningCode, errorCode;
	logic [VAL_W-1:0] appliedActivePower, appliedReactivePower, appliedPowerFactor;
	logic [VAL_W-1:0] appliedDcVoltage, appliedNominalVoltage;
	int error_cnt = 0, n_tests = 0, cycles = 0, m;
	cfs_supervisor #(.TICK_CYCLES(TK)) uut (.*);
	cfs_setpoint_source src (.*);
	// ============
	// clock, watchdog and helpers
	initial
		forever #50 ref_clk = ~ref_clk;
	// a hung wait ends here as a failure
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	// bounded wait on detection (sel 0) or enhanced status (sel 1)
	task waitSt(input bit sel, input logic [1:0] v, input int maxc);
		logic [1:0] s;
		for (int i = 0; i < maxc; i++)
		begin
			s = sel ? 2'(enhancedStatus) : 2'(detectionStatus);
			if (s === v)
				break;
			cyc(1);
		end
		s = sel ? 2'(enhancedStatus) : 2'(detectionStatus);
		chk(16'(s), 16'(v));
	endtask : waitSt
	// links healthy again and fresh frames on both paths
	task recover;
		{scadaLinkFail, batteryLinkFail, internalLinkFail} = 3'h0;
		cyc(3);
		src.sendScada(16'h1000);
		src.sendBattery(16'h2000);
		cyc(2);
	endtask : recover
	task enhFail;
		scadaLinkFail = 1'b1;
		waitSt(1, ES_T30, 4 * TK);
	endtask : enhFail
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// ============
	// scenarios
	initial
	begin
		cyc(10);
		rst = 1'b0;
		cyc(2);
		chk(detectionStatus, DS_OK);
		chk(feedingState, 1'b1);
		chk(scadaPathEnableRd, 1'b1);
		chk(batteryPathEnableRd, 1'b1);
		// no frame since reset, so last-setpoint falls to standby
		scadaLinkFail = 1'b1;
		cyc(2 * TK);
		chk(detectionStatus, DS_OK);
		waitSt(0, DS_FALLBACK, 2 * TK);
		chk(operatingState, OP_STANDBY);
		chk(failureCause, 3'h1);
		chk(freqPowerMode, 2'h2);
		waitSt(0, DS_ERROR, 5 * TK);
		chk(feedingState, 1'b0);
		recover();
		chk(detectionStatus, DS_OK);
		chk(freqPowerMode, 2'h1);
		// now a frame exists: last value is reused
		scadaLinkFail = 1'b1;
		waitSt(0, DS_FALLBACK, 5 * TK);
		chk(operatingState, OP_FEED);
		chk(appliedActivePower, 16'h1000);
		recover();
		// standby keeps switchgear closed; healthy path still steers
		fallbackBehaviourSelect = FB_STANDBY;
		batteryLinkFail = 1'b1;
		waitSt(0, DS_FALLBACK, 4 * TK);
		chk(operatingState, OP_STANDBY);
		chk({acDisconnectOpen, dcSwitchgearOpen}, 2'h0);
		chk(failureCause, 3'h2);
		src.sendScada(16'h3000);
		cyc(2);
		chk(appliedActivePower, 16'h3000);
		chk(detectionStatus, DS_FALLBACK);
		recover();
		// error behaviour with zero duration
		fallbackBehaviourSelect = FB_ERROR;
		fallbackDurationLimit = 16'h0000;
		batteryLinkFail = 1'b1;
		waitSt(0, DS_FALLBACK, 4 * TK);
		chk({acDisconnectOpen, dcSwitchgearOpen}, 2'h3);
		cyc(2);
		chk(detectionStatus, DS_ERROR);
		chk(operatingState, OP_ERROR);
		recover();
		// internal failure takes the shorter tolerance; all control modes
		fallbackBehaviourSelect = FB_PREDEF;
		fallbackDurationLimit = 16'h0003;
		scadaToleranceTime = 16'h0005;
		for (m = 0; m < 3; m++)
		begin
			fallbackControlMode = cfs_ctl_t'(m);
			liveControlMode = (m == 0) ? CM_DCVOLT : CM_POWER;
			internalLinkFail = 1'b1;
			waitSt(0, DS_FALLBACK, 3 * TK);
			chk(failureCause, 3'h4);
			// last mode must ignore a live mode change made after the loss
			if (m == 2)
				liveControlMode = CM_DCVOLT;
			cyc(2);
			chk(appliedControlMode, (m == 2) ? CM_POWER : fallbackControlMode);
			chk(appliedActivePower, substituteActivePower);
			chk(appliedReactivePower, substituteReactivePower);
			chk(appliedPowerFactor, substitutePowerFactor);
			chk(appliedDcVoltage, substituteDcVoltage);
			chk(appliedNominalVoltage, substituteNominalVoltage);
			recover();
		end
		// disabled paths are not supervised
		{scadaPathEnable, batteryPathEnable} = 2'h0;
		{scadaLinkFail, batteryLinkFail} = 2'h3;
		cyc(10 * TK);
		chk(scadaPathEnableRd, 1'b0);
		chk(batteryPathEnableRd, 1'b0);
		chk(detectionStatus, DS_OK);
		chk(failureCause, 3'h0);
		{scadaPathEnable, batteryPathEnable} = 2'h3;
		recover();
		// enhanced: loss outlasts the recheck window
		enhancedHandlingEnable = 1'b1;
		fallbackBehaviourSelect = FB_STANDBY;
		enhFail();
		chk(warningCode, 16'h2484);
		cyc(25 * TK);
		chk(detectionStatus, DS_OK);
		waitSt(0, DS_FALLBACK, 10 * TK);
		waitSt(1, ES_FLB_ERR, 5 * TK);
		chk(errorCode, 16'h17F8);
		chk(feedingState, 1'b0);
		recover();
		chk(detectionStatus, DS_ERROR);
		enhancedErrorClear = 1'b1;
		cyc(2);
		enhancedErrorClear = 1'b0;
		cyc(2);
		chk(detectionStatus, DS_OK);
		// recovered in time, then lost inside the watch
		enhFail();
		recover();
		waitSt(1, ES_T1H, 2 * TK);
		scadaLinkFail = 1'b1;
		waitSt(0, DS_FALLBACK, 4 * TK);
		waitSt(1, ES_FLB_ERR, 5 * TK);
		chk(errorCode, 16'h17F8);
		recover();
		enhancedErrorClear = 1'b1;
		cyc(2);
		enhancedErrorClear = 1'b0;
		// a quiet hour resolves the fault; the next loss rechecks afresh
		enhFail();
		recover();
		waitSt(1, ES_T1H, 2 * TK);
		cyc(3500 * TK);
		chk(enhancedStatus, ES_T1H);
		waitSt(1, ES_INACTIVE, 200 * TK);
		chk(warningCode, 16'h0000);
		enhFail();
		end_of_test();
	end
endmodule : test_comm_fallback_supervisor
`default_nettype wire
